/* File: rtl/strap_cfg_pkg.sv */
package strap_cfg_pkg;

    // host port modes
    typedef enum logic {
        host_i2c_type = 1'b0,
        host_spi_type = 1'b1
    } host_mode_type;

    // electrical format of one output
    typedef enum logic [1:0] {
        fmt_unused_type = 2'h0,
        fmt_diff_type = 2'h1,
        fmt_cmos_type = 2'h2
    } out_fmt_type;

    // output frequency codes
    typedef enum logic [1:0] {
        freq_none_type = 2'h0,
        freq_25m_type = 2'h1,
        freq_75m_type = 2'h2,
        freq_100m_type = 2'h3
    } out_freq_type;

    // reference source selection codes
    localparam logic [1:0] REF_SEL_RESET = 2'h0;
    localparam logic [1:0] REF_SEL_OSC = 2'h2;
    localparam logic [1:0] REF_SEL_XTAL = 2'h1;

    localparam logic [6:0] I2C_SLAVE_ADDR = 7'h77;
    localparam logic [2:0] CFG_RESET = 3'h0;
    localparam int NUM_OUTPUTS = 6;
    localparam int SPREAD_BIT = 2;

    // minimum reset low time, for the board side
    localparam int RESET_MIN_NS = 1000;
    localparam int CLOCK_PERIOD_NS = 20;
    localparam int RESET_MIN_CYCLES =
        (RESET_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

    // captured strap levels
    typedef struct packed {
        logic test_mode;
        logic [1:0] host_sel;
        logic [2:0] config_number;
    } strap_status_type;

    localparam strap_status_type STRAP_RESET = 6'h00;

    // plan of one output clock
    typedef struct packed {
        out_fmt_type fmt;
        out_freq_type freq;
        logic from_second_div;
        logic spread;
    } out_plan_type;

    localparam out_plan_type PLAN_RESET = 6'h00;

endpackage : strap_cfg_pkg

/* File: rtl/reset_strap_config_sampler.sv */
`timescale 1ns/1ns
// What this block does
// R1 - sample straps on reset rising edge
// R2 - store captured straps in status register
// R3 - dual-purpose pins switch to run-time role
// R4 - test strap high enters manufacturing test
// R5 - host select straps pick I2C or SPI
// R6 - three straps pick one of eight plans
// R7 - code 000 basic plan, output 3-5 unused
// R8 - code 001 all outputs used, 25MHz cmos
// R9 - code 010 like 001 with 75MHz cmos
// R10 - code 011 all outputs 100MHz differential
// R11 - code 100: output 6 spread from divider two
// R12 - codes 101-111: outputs 3-6 spread
// R13 - select 10 enables oscillator input on pin a
// R14 - select 01 enables crystal driver
// R15 - asynchronous reset restores defaults, held while low
// R16 - board holds reset low at least 1us
// R17 - test pin becomes pll lock output
// R18 - spi master drives chip select, never floats
// R19 - captured straps stay fixed until next reset
module reset_strap_config_sampler (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic factory_test_lock_pin_in,
    output logic factory_test_lock_pin_out,
    output logic factory_test_lock_pin_oe,
    input wire logic host_sel0_chip_select_pin_in,
    input wire logic host_sel1_serial_out_pin_in,
    output logic host_sel1_serial_out_pin_out,
    output logic host_sel1_serial_out_pin_oe,
    input wire logic [2:0] config_number_straps,
    input wire logic pll_lock_indicator,
    input wire logic spi_serial_out,
    input wire logic spi_serial_out_en,
    input wire logic [1:0] ref_source_select,
    output strap_cfg_pkg::strap_status_type strap_capture_status,
    output logic run_mode,
    output logic test_mode,
    output strap_cfg_pkg::host_mode_type host_mode,
    output logic [6:0] i2c_slave_addr,
    output logic spi_chip_select_b,
    output logic spread_spectrum,
    output strap_cfg_pkg::out_plan_type [5:0] out_plan,
    output logic ref_osc_input_en,
    output logic ref_pin_b_unused,
    output logic ref_xtal_driver_en
);

    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [5:0] strap_meta_ff;
    logic [5:0] strap_sync_ff;
    logic cs_meta_ff;
    logic cs_sync_ff;
    logic lock_meta_ff;
    logic lock_sync_ff;
    logic run_mode_ff;
    strap_cfg_pkg::strap_status_type status_ff;
    strap_cfg_pkg::out_plan_type [5:0] plan_ff;
    strap_cfg_pkg::out_plan_type [5:0] nxt_plan;
    logic test_mode_ff;
    logic host_spi_ff;
    logic spread_ff;
    logic osc_en_ff;
    logic xtal_en_ff;
    logic lock_out_ff;
    logic lock_oe_ff;
    logic miso_out_ff;
    logic miso_oe_ff;
    logic cs_b_ff;

    // reset release through two flip-flops [R15]
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // strap pins and run-time inputs synchronised
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            strap_meta_ff <= 6'h00;
            strap_sync_ff <= 6'h00;
            cs_meta_ff <= 1'b1;
            cs_sync_ff <= 1'b1;
            lock_meta_ff <= 1'b0;
            lock_sync_ff <= 1'b0;
        end else begin
            strap_meta_ff <= {factory_test_lock_pin_in,
                              host_sel1_serial_out_pin_in,
                              host_sel0_chip_select_pin_in,
                              config_number_straps};
            strap_sync_ff <= strap_meta_ff;
            cs_meta_ff <= host_sel0_chip_select_pin_in;
            cs_sync_ff <= cs_meta_ff;
            lock_meta_ff <= pll_lock_indicator;
            lock_sync_ff <= lock_meta_ff;
        end
    end

    // strap decode
    wire logic capture = rst_sync_ff && !run_mode_ff;
    wire logic [2:0] cfg_num = strap_sync_ff[2:0];
    wire logic cap_test = strap_sync_ff[5];
    wire logic [1:0] cap_host = strap_sync_ff[4:3];
    wire logic cap_spi = &cap_host; // [R5]
    wire logic cap_spread = cfg_num[strap_cfg_pkg::SPREAD_BIT]; // [R6]
    wire logic [1:0] base_cfg = cfg_num[1:0];
    wire logic sel_osc = ref_source_select == strap_cfg_pkg::REF_SEL_OSC;
    wire logic sel_xtal = ref_source_select == strap_cfg_pkg::REF_SEL_XTAL;

    // per-output plan from config number [R6]
    always_comb begin
        strap_cfg_pkg::out_plan_type diff;
        diff = '{fmt: strap_cfg_pkg::fmt_diff_type,
                 freq: strap_cfg_pkg::freq_100m_type,
                 from_second_div: 1'b0, spread: 1'b0};
        nxt_plan[0] = diff;
        nxt_plan[1] = '{fmt: strap_cfg_pkg::fmt_cmos_type,
                        freq: strap_cfg_pkg::freq_25m_type,
                        from_second_div: 1'b0, spread: 1'b0}; // [R7] [R8]
        if (base_cfg == 2'h2) begin
            nxt_plan[1].freq = strap_cfg_pkg::freq_75m_type; // [R9]
        end
        if (base_cfg == 2'h3) begin
            nxt_plan[1] = diff; // [R10]
        end
        for (int i = 2; i < strap_cfg_pkg::NUM_OUTPUTS; i++) begin
            nxt_plan[i] = diff;
            if (base_cfg == 2'h0 && i < 5) begin
                nxt_plan[i] = strap_cfg_pkg::PLAN_RESET; // [R7]
            end else if (cap_spread) begin
                nxt_plan[i].from_second_div = 1'b1; // [R11] [R12]
                nxt_plan[i].spread = 1'b1;
            end
        end
    end

    // one-shot capture at reset release, frozen afterwards
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_mode_ff <= 1'b0;
            status_ff <= strap_cfg_pkg::STRAP_RESET;
            plan_ff <= {6{strap_cfg_pkg::PLAN_RESET}};
            test_mode_ff <= 1'b0;
            host_spi_ff <= 1'b0;
            spread_ff <= 1'b0;
        end else if (capture) begin // [R1] [R19]
            run_mode_ff <= 1'b1; // [R3]
            status_ff <= '{test_mode: cap_test, host_sel: cap_host,
                           config_number: cfg_num}; // [R2]
            plan_ff <= nxt_plan;
            test_mode_ff <= cap_test; // [R4]
            host_spi_ff <= cap_spi; // [R5]
            spread_ff <= cap_spread;
        end
    end

    // reference source and run-time pin roles
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            osc_en_ff <= 1'b0;
            xtal_en_ff <= 1'b0;
            lock_out_ff <= 1'b0;
            lock_oe_ff <= 1'b0;
            miso_out_ff <= 1'b0;
            miso_oe_ff <= 1'b0;
            cs_b_ff <= 1'b1;
        end else begin
            osc_en_ff <= sel_osc; // [R13]
            xtal_en_ff <= sel_xtal; // [R14]
            lock_out_ff <= run_mode_ff && lock_sync_ff; // [R17]
            lock_oe_ff <= run_mode_ff; // [R3] [R17]
            miso_out_ff <= spi_serial_out;
            miso_oe_ff <= run_mode_ff && host_spi_ff
                          && spi_serial_out_en; // [R3]
            cs_b_ff <= !(run_mode_ff && host_spi_ff) || cs_sync_ff; // [R18]
        end
    end

    assign strap_capture_status = status_ff;
    assign run_mode = run_mode_ff;
    assign test_mode = test_mode_ff;
    assign host_mode = host_spi_ff ? strap_cfg_pkg::host_spi_type
                                   : strap_cfg_pkg::host_i2c_type;
    assign i2c_slave_addr = strap_cfg_pkg::I2C_SLAVE_ADDR; // [R5]
    assign spi_chip_select_b = cs_b_ff;
    assign spread_spectrum = spread_ff;
    assign out_plan = plan_ff;
    assign ref_osc_input_en = osc_en_ff;
    assign ref_pin_b_unused = osc_en_ff; // [R13]
    assign ref_xtal_driver_en = xtal_en_ff;
    assign factory_test_lock_pin_out = lock_out_ff;
    assign factory_test_lock_pin_oe = lock_oe_ff;
    assign host_sel1_serial_out_pin_out = miso_out_ff;
    assign host_sel1_serial_out_pin_oe = miso_oe_ff;

endmodule : reset_strap_config_sampler

/* File: bench/strap_board.sv */
`timescale 1ns/1ns
module strap_board (
    input wire logic clock,
    output logic rst_b,
    output logic [5:0] pins
);
    initial begin
        rst_b = 1'b0;
        pins = 6'h00;
    end
    task automatic cap(input logic [5:0] v);
        rst_b <= 1'b0;
        pins <= v;
        repeat (strap_cfg_pkg::RESET_MIN_CYCLES) @(negedge clock);
        rst_b <= 1'b1;
        repeat (4) @(negedge clock);
        pins <= ~v;
    endtask : cap
    task automatic drop;
        rst_b <= 1'b0;
    endtask : drop
endmodule : strap_board

/* File: bench/strap_chk.sv */
`timescale 1ns/1ns
module strap_chk (
    input wire logic clock,
    input wire logic rst_b,
    input wire strap_cfg_pkg::strap_status_type strap_capture_status,
    input wire logic run_mode,
    input wire logic test_mode,
    input wire strap_cfg_pkg::host_mode_type host_mode,
    input wire logic spread_spectrum,
    input wire logic [1:0] ref_source_select,
    input wire logic ref_osc_input_en,
    input wire logic ref_xtal_driver_en,
    input wire logic factory_test_lock_pin_oe
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_cap;
        $rose(run_mode);
    endsequence
    sequence s_up;
        run_mode ##1 run_mode;
    endsequence
    a_status_hold: assert property (s_up |->
        $stable(strap_capture_status)) else $error("status moved");
    a_host_decode: assert property (run_mode |-> host_mode ==
        (strap_capture_status.host_sel == 2'h3)) else $error("host mode");
    a_test_latch: assert property (run_mode |->
        test_mode == strap_capture_status.test_mode) else $error("test");
    a_spread_code: assert property (run_mode |-> spread_spectrum ==
        strap_capture_status.config_number[2]) else $error("spread");
    a_osc_select: assert property (run_mode &&
        ref_source_select == 2'h2
        |=> ref_osc_input_en && !ref_xtal_driver_en) else $error("osc");
    a_xtal_select: assert property (run_mode &&
        ref_source_select == 2'h1
        |=> ref_xtal_driver_en && !ref_osc_input_en) else $error("xtal");
    a_lock_role: assert property (s_cap |=> factory_test_lock_pin_oe)
        else $error("lock role");
    a_run_after: assert property ($rose(rst_b) |->
        !run_mode[*3] ##1 run_mode) else $error("capture time");
endmodule : strap_chk
bind reset_strap_config_sampler strap_chk strap_chk_inst (.clock, .rst_b,
    .strap_capture_status, .run_mode, .test_mode, .host_mode,
    .spread_spectrum, .ref_source_select, .ref_osc_input_en,
    .ref_xtal_driver_en, .factory_test_lock_pin_oe);

/* File: bench/tb_reset_strap_config_sampler.sv */
`timescale 1ns/1ns
module tb_reset_strap_config_sampler;
    logic clock = 1'b0;
    logic rst_b, lock = 1'b0, so = 1'b0, so_en = 1'b0, t_out, t_oe, m_out;
    logic m_oe, run, tst, cs_b, spr, osc, bun, xtal;
    logic [5:0] pins;
    logic [1:0] rsel = 2'h0;
    logic [6:0] addr;
    strap_cfg_pkg::strap_status_type st;
    strap_cfg_pkg::host_mode_type hm;
    strap_cfg_pkg::out_plan_type [5:0] plan;
    int bad_count = 0;
    int num_checks = 0;
    strap_board strap_board_inst (.clock(clock), .rst_b(rst_b), .pins(pins));
    reset_strap_config_sampler reset_strap_config_sampler_inst (
        .clock(clock), .rst_b(rst_b),
        .factory_test_lock_pin_in(t_oe ? t_out : pins[5]),
        .factory_test_lock_pin_out(t_out), .factory_test_lock_pin_oe(t_oe),
        .host_sel0_chip_select_pin_in(pins[3]),
        .host_sel1_serial_out_pin_in(m_oe ? m_out : pins[4]),
        .host_sel1_serial_out_pin_out(m_out),
        .host_sel1_serial_out_pin_oe(m_oe),
        .config_number_straps(pins[2:0]), .pll_lock_indicator(lock),
        .spi_serial_out(so), .spi_serial_out_en(so_en),
        .ref_source_select(rsel), .strap_capture_status(st),
        .run_mode(run), .test_mode(tst), .host_mode(hm),
        .i2c_slave_addr(addr), .spi_chip_select_b(cs_b),
        .spread_spectrum(spr), .out_plan(plan), .ref_osc_input_en(osc),
        .ref_pin_b_unused(bun), .ref_xtal_driver_en(xtal));
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    function automatic logic [35:0] plan_for(input logic [2:0] c);
        logic [5:0] d, m;
        d = {4'h7, c[2], c[2]};
        m = (c[1:0] == 2'h3) ? 6'h1C : {4'h9 + {3'h0, c[1]}, 2'h0};
        plan_for = {d, (c[1:0] == 2'h0) ? 18'h0 : {3{d}}, m, 6'h1C};
    endfunction : plan_for
    task automatic cfg_sweep;
        logic [5:0] v;
        for (int i = 0; i < 8; i++) begin
            v = {i == 5, i[1:0], i[2:0]};
            strap_board_inst.cap(v);
            repeat (6) @(negedge clock);
            chk(st, v);
            chk(tst, v[5]);
            chk({hm, addr}, {v[4:3] == 2'h3, 7'h77});
            chk(cs_b, v[4:3] != 2'h3);
            chk(spr, v[2]);
            chk(plan, plan_for(v[2:0]));
        end
    endtask : cfg_sweep
    task automatic roles;
        {lock, so, so_en} = 3'h7;
        repeat (4) @(negedge clock);
        chk({t_oe, t_out, m_oe, m_out}, 4'hF);
        {lock, so} = 2'h0;
        repeat (4) @(negedge clock);
        chk({t_out, m_out}, 2'h0);
    endtask : roles
    task automatic ref_sweep;
        for (int i = 0; i < 4; i++) begin
            rsel = i[1:0];
            repeat (2) @(negedge clock);
            chk({osc, bun, xtal}, {i == 2, i == 2, i == 1});
        end
    endtask : ref_sweep
    task automatic mid_reset;
        strap_board_inst.drop();
        @(negedge clock);
        chk({run, st, cs_b, t_oe, osc}, 10'h4);
    endtask : mid_reset
    task automatic wrap_up;
        $display("checks %0d errors %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    initial begin
        forever #10 clock = ~clock;
    end
    initial begin
        repeat (100000) @(posedge clock);
        bad_count++;
        wrap_up();
    end
    initial begin
        repeat (10) @(negedge clock);
        cfg_sweep();
        roles();
        ref_sweep();
        mid_reset();
        wrap_up();
    end
endmodule : tb_reset_strap_config_sampler
